// ==== psc_pkg.sv ====
package psc_pkg;
    // register byte offsets
    localparam logic [7:0] REG_CONFIG = 8'h00;
    localparam logic [7:0] REG_STATUS = 8'h04;
    localparam logic [7:0] REG_WAIT = 8'h08;
    localparam logic [7:0] REG_CTRL = 8'h0c;
    // config register fields
    localparam int CFG_ADDR_LSB = 0;
    localparam int CFG_SLOT_LSB = 8;
    localparam int CFG_NODES_LSB = 16;
    localparam int CFG_ARB_OFF_BIT = 24;
    localparam int CFG_HDR_EXT_BIT = 25;
    localparam int CFG_ACK_EXT_BIT = 26;
    // status register fields
    localparam int ST_UNINIT_BIT = 0;
    localparam int ST_ERR_BIT = 1;
    localparam int ST_CMP_BIT = 2;
    localparam int ST_RANGE_BIT = 3;
    localparam int ST_SLOT_BIT = 4;
    localparam int ST_LOADED_BIT = 5;
    // ctrl register fields
    localparam int CTRL_SKIP_BIT = 0;
    localparam int CTRL_SKIP_RESET = 0;
    // node address limits
    localparam logic [7:0] ADDR_MAX = 8'hdf;
    // boot wait
    localparam int BOOT_STEP_S = 100;
    localparam int BOOT_MAX_S = 1500;
    localparam int CLK_HZ = 100000000;
    localparam longint SEC_CYCLES = longint'(CLK_HZ);
    // node counts
    localparam logic [7:0] NODES_16 = 8'h10;
    localparam logic [7:0] NODES_32 = 8'h20;
    localparam logic [7:0] NODES_64 = 8'h40;
    localparam logic [7:0] NODES_128 = 8'h80;
    // quiet slot counts
    localparam logic [5:0] SLOT_7 = 6'h07;
    localparam logic [5:0] SLOT_10 = 6'h0a;
    localparam logic [5:0] SLOT_14 = 6'h0e;
    localparam logic [5:0] SLOT_16 = 6'h10;
    localparam logic [5:0] SLOT_21 = 6'h15;
    localparam logic [5:0] SLOT_25 = 6'h19;
    localparam logic [5:0] SLOT_32 = 6'h20;
    // axi responses
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
    typedef enum logic [1:0] {
        PSC_SETTLE,
        PSC_UNINIT,
        PSC_READY,
        PSC_FAULT
    } psc_state_type;
endpackage : psc_pkg

// ==== psc_strap_config.sv ====
// Our own choices: the placing of the registers and the AXI4-Lite slave port.
`timescale 1ns/10ps
// Overview of operation
// - address straps weight bit 7 down to 0
// - addresses above 223 are invalid
// - stay uninitialized for selected boot wait
// - four boot straps select 1500 down to 0
// - arbitration-disable strap bypasses arbitration
// - header-extension strap lengthens sync header
// - delta straps pick quiet slot count
// - two straps pick 16 to 128 nodes
// - ack-extension strap lengthens ack timeout
module psc_strap_config #(
    parameter longint SEC_CYCLES = psc_pkg::SEC_CYCLES,
    parameter logic [7:0] HDR_SYNC_NORMAL = 8'h04,
    parameter logic [7:0] HDR_SYNC_EXT = 8'h08,
    parameter logic [15:0] ACK_TMO_NORMAL = 16'h0100,
    parameter logic [15:0] ACK_TMO_EXT = 16'h0400,
    parameter int SLOT_HIGH_BIT = 2
) (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [7:0] strap_addr,
    input wire logic [7:0] strap_addr_cmp,
    input wire logic [3:0] strap_boot,
    input wire logic strap_arb_off,
    input wire logic strap_hdr_ext,
    input wire logic [2:0] strap_delta,
    input wire logic [1:0] strap_nodes,
    input wire logic strap_ack_ext,
    output logic [7:0] node_address,
    output logic address_valid,
    output logic uninitialized_link_state,
    output logic config_error,
    output logic arbitration_bypass,
    output logic [7:0] header_sync_count,
    output logic [5:0] quiet_slot_count,
    output logic [7:0] arb_node_count,
    output logic [15:0] ack_timeout,
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready
);
    localparam int NS = 28;
    // boot wait in seconds from the four straps, msb is first strap
    function automatic logic [10:0] boot_secs(input logic [3:0] s);
        logic [3:0] step;
        step = 4'h0;
        case (s)
            4'h0: step = 4'h0;
            4'h1: step = 4'h1;
            4'h3: step = 4'h2;
            4'h2: step = 4'h3;
            4'h4: step = 4'h4;
            4'h5: step = 4'h5;
            4'h6: step = 4'h6;
            4'h7: step = 4'h7;
            4'h8: step = 4'h8;
            4'h9: step = 4'h9;
            4'ha: step = 4'ha;
            4'hb: step = 4'hb;
            4'hc: step = 4'hc;
            4'hd: step = 4'hd;
            4'he: step = 4'he;
            default: step = 4'hf;
        endcase
        boot_secs = 11'(psc_pkg::BOOT_MAX_S - int'(step) *
            psc_pkg::BOOT_STEP_S);
    endfunction : boot_secs

    // synchronisers for all straps
    logic [NS-1:0] raw;
    logic [NS-1:0] sync1;
    logic [NS-1:0] sync2;
    logic [NS-1:0] samp;
    assign raw = {strap_addr, strap_addr_cmp, strap_boot, strap_arb_off,
        strap_hdr_ext, strap_delta, strap_nodes, strap_ack_ext};
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            sync1 <= '0;
            sync2 <= '0;
        end else begin
            sync1 <= raw;
            sync2 <= sync1;
        end
    end

    psc_pkg::psc_state_type state;
    psc_pkg::psc_state_type next_state;
    logic [1:0] settle;
    logic [1:0] next_settle;
    logic [10:0] secs_left;
    logic [10:0] next_secs_left;
    logic [31:0] tick;
    logic [31:0] next_tick;
    logic [NS-1:0] next_samp;
    logic loaded;
    logic next_loaded;
    logic skip_wait;
    logic next_skip_wait;

    logic [7:0] s_addr;
    logic [7:0] s_cmp;
    logic [2:0] s_delta;
    logic [1:0] s_nodes;
    logic s_arb;
    logic s_hdr;
    logic s_ack;
    logic err_cmp;
    logic err_range;
    logic err_slot;
    // boot straps sit in samp[11:8] and are only read at the latch
    assign s_addr = samp[27:20];
    assign s_cmp = samp[19:12];
    assign s_arb = samp[7];
    assign s_hdr = samp[6];
    assign s_delta = samp[5:3];
    assign s_nodes = samp[2:1];
    assign s_ack = samp[0];
    assign err_cmp = loaded && (s_cmp != s_addr);
    assign err_range = loaded && (s_addr > psc_pkg::ADDR_MAX);
    assign err_slot = loaded && (s_delta == 3'h7);

    always_comb begin
        next_state = state;
        next_settle = settle;
        next_secs_left = secs_left;
        next_tick = tick;
        next_samp = samp;
        next_loaded = loaded;
        case (state)
            psc_pkg::PSC_SETTLE: begin
                // wait for synchronisers to fill, then latch straps
                next_settle = settle + 2'h1;
                if (settle == 2'h3) begin
                    next_samp = sync2;
                    next_loaded = 1'b1;
                    next_secs_left = boot_secs(sync2[11:8]);
                    next_tick = 32'h0;
                    next_state = psc_pkg::PSC_UNINIT;
                end
            end
            psc_pkg::PSC_UNINIT: begin
                if (err_cmp || err_range || err_slot) begin
                    next_state = psc_pkg::PSC_FAULT;
                end else if (secs_left == 11'h0 || skip_wait) begin
                    next_state = psc_pkg::PSC_READY;
                end else if (tick == 32'(SEC_CYCLES - 1)) begin
                    next_tick = 32'h0;
                    next_secs_left = secs_left - 11'h1;
                end else begin
                    next_tick = tick + 32'h1;
                end
            end
            psc_pkg::PSC_READY: next_state = psc_pkg::PSC_READY;
            psc_pkg::PSC_FAULT: next_state = psc_pkg::PSC_FAULT;
            default: next_state = psc_pkg::PSC_SETTLE;
        endcase
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            state <= psc_pkg::PSC_SETTLE;
            settle <= 2'h0;
            secs_left <= 11'h0;
            tick <= 32'h0;
            samp <= '0;
            loaded <= 1'b0;
        end else begin
            state <= next_state;
            settle <= next_settle;
            secs_left <= next_secs_left;
            tick <= next_tick;
            samp <= next_samp;
            loaded <= next_loaded;
        end
    end

    // decoded outputs, registered
    logic [5:0] next_slot;
    logic [7:0] next_nodes;
    always_comb begin
        case ({s_delta[SLOT_HIGH_BIT], s_delta[1:0]})
            3'h0: next_slot = psc_pkg::SLOT_7;
            3'h1: next_slot = psc_pkg::SLOT_10;
            3'h2: next_slot = psc_pkg::SLOT_14;
            3'h3: next_slot = psc_pkg::SLOT_16;
            3'h4: next_slot = psc_pkg::SLOT_21;
            3'h5: next_slot = psc_pkg::SLOT_25;
            3'h6: next_slot = psc_pkg::SLOT_32;
            default: next_slot = psc_pkg::SLOT_7;
        endcase
        case (s_nodes)
            2'h0: next_nodes = psc_pkg::NODES_16;
            2'h1: next_nodes = psc_pkg::NODES_32;
            2'h2: next_nodes = psc_pkg::NODES_64;
            default: next_nodes = psc_pkg::NODES_128;
        endcase
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            node_address <= 8'h00;
            address_valid <= 1'b0;
            uninitialized_link_state <= 1'b1;
            config_error <= 1'b0;
            arbitration_bypass <= 1'b0;
            header_sync_count <= HDR_SYNC_NORMAL;
            quiet_slot_count <= psc_pkg::SLOT_7;
            arb_node_count <= psc_pkg::NODES_16;
            ack_timeout <= ACK_TMO_NORMAL;
        end else begin
            node_address <= s_addr;
            address_valid <= loaded && !err_cmp && !err_range;
            uninitialized_link_state <= (next_state !=
                psc_pkg::PSC_READY);
            config_error <= (next_state == psc_pkg::PSC_FAULT);
            arbitration_bypass <= s_arb;
            header_sync_count <= s_hdr ? HDR_SYNC_EXT :
                HDR_SYNC_NORMAL;
            quiet_slot_count <= next_slot;
            arb_node_count <= next_nodes;
            ack_timeout <= s_ack ? ACK_TMO_EXT : ACK_TMO_NORMAL;
        end
    end

    // axi4-lite slave, answers one cycle after both halves are taken
    logic aw_held;
    logic next_aw_held;
    logic w_held;
    logic next_w_held;
    logic [7:0] aw_addr;
    logic [7:0] next_aw_addr;
    logic [31:0] w_data;
    logic [31:0] next_w_data;
    logic [3:0] w_strb;
    logic [3:0] next_w_strb;
    logic next_bvalid;
    logic [1:0] next_bresp;
    logic next_rvalid;
    logic [1:0] next_rresp;
    logic [31:0] next_rdata;
    logic [31:0] cfg_word;
    logic [31:0] st_word;
    assign s_axi_awready = !aw_held && !s_axi_bvalid;
    assign s_axi_wready = !w_held && !s_axi_bvalid;
    assign s_axi_arready = !s_axi_rvalid;
    always_comb begin
        cfg_word = 32'h0;
        cfg_word[psc_pkg::CFG_ADDR_LSB +: 8] = node_address;
        cfg_word[psc_pkg::CFG_SLOT_LSB +: 6] = quiet_slot_count;
        cfg_word[psc_pkg::CFG_NODES_LSB +: 8] = arb_node_count;
        cfg_word[psc_pkg::CFG_ARB_OFF_BIT] = arbitration_bypass;
        cfg_word[psc_pkg::CFG_HDR_EXT_BIT] = s_hdr;
        cfg_word[psc_pkg::CFG_ACK_EXT_BIT] = s_ack;
        st_word = 32'h0;
        st_word[psc_pkg::ST_UNINIT_BIT] = uninitialized_link_state;
        st_word[psc_pkg::ST_ERR_BIT] = config_error;
        st_word[psc_pkg::ST_CMP_BIT] = err_cmp;
        st_word[psc_pkg::ST_RANGE_BIT] = err_range;
        st_word[psc_pkg::ST_SLOT_BIT] = err_slot;
        st_word[psc_pkg::ST_LOADED_BIT] = loaded;
    end
    always_comb begin
        next_aw_held = aw_held;
        next_w_held = w_held;
        next_aw_addr = aw_addr;
        next_w_data = w_data;
        next_w_strb = w_strb;
        next_bvalid = s_axi_bvalid;
        next_bresp = s_axi_bresp;
        next_skip_wait = skip_wait;
        next_rvalid = s_axi_rvalid;
        next_rresp = s_axi_rresp;
        next_rdata = s_axi_rdata;
        if (s_axi_awvalid && s_axi_awready) begin
            next_aw_held = 1'b1;
            next_aw_addr = s_axi_awaddr;
        end
        if (s_axi_wvalid && s_axi_wready) begin
            next_w_held = 1'b1;
            next_w_data = s_axi_wdata;
            next_w_strb = s_axi_wstrb;
        end
        if (aw_held && w_held) begin
            next_aw_held = 1'b0;
            next_w_held = 1'b0;
            next_bvalid = 1'b1;
            next_bresp = psc_pkg::RESP_OKAY;
            if ({aw_addr[7:2], 2'h0} == psc_pkg::REG_CTRL) begin
                if (w_strb[0]) begin
                    next_skip_wait = w_data[psc_pkg::CTRL_SKIP_BIT];
                end
            end else if ({aw_addr[7:2], 2'h0} != psc_pkg::REG_CONFIG &&
                {aw_addr[7:2], 2'h0} != psc_pkg::REG_STATUS &&
                {aw_addr[7:2], 2'h0} != psc_pkg::REG_WAIT) begin
                next_bresp = psc_pkg::RESP_SLVERR;
            end
        end else if (s_axi_bvalid && s_axi_bready) begin
            next_bvalid = 1'b0;
        end
        if (s_axi_arvalid && s_axi_arready) begin
            next_rvalid = 1'b1;
            next_rresp = psc_pkg::RESP_OKAY;
            case ({s_axi_araddr[7:2], 2'h0})
                psc_pkg::REG_CONFIG: next_rdata = cfg_word;
                psc_pkg::REG_STATUS: next_rdata = st_word;
                psc_pkg::REG_WAIT: next_rdata = {21'h0, secs_left};
                psc_pkg::REG_CTRL: next_rdata = {31'h0, skip_wait};
                default: begin
                    next_rdata = 32'h0;
                    next_rresp = psc_pkg::RESP_SLVERR;
                end
            endcase
        end else if (s_axi_rvalid && s_axi_rready) begin
            next_rvalid = 1'b0;
        end
    end
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_held <= 1'b0;
            w_held <= 1'b0;
            aw_addr <= 8'h00;
            w_data <= 32'h0;
            w_strb <= 4'h0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= psc_pkg::RESP_OKAY;
            skip_wait <= 1'(psc_pkg::CTRL_SKIP_RESET);
            s_axi_rvalid <= 1'b0;
            s_axi_rresp <= psc_pkg::RESP_OKAY;
            s_axi_rdata <= 32'h0;
        end else begin
            aw_held <= next_aw_held;
            w_held <= next_w_held;
            aw_addr <= next_aw_addr;
            w_data <= next_w_data;
            w_strb <= next_w_strb;
            s_axi_bvalid <= next_bvalid;
            s_axi_bresp <= next_bresp;
            skip_wait <= next_skip_wait;
            s_axi_rvalid <= next_rvalid;
            s_axi_rresp <= next_rresp;
            s_axi_rdata <= next_rdata;
        end
    end

    // assertions
    property p_addr_follows;
        @(posedge aclk) disable iff (!aresetn)
        loaded |=> node_address == $past(s_addr);
    endproperty
    a_addr_follows: assert property (p_addr_follows)
        else $error("node address does not follow straps");
    property p_range_bad;
        @(posedge aclk) disable iff (!aresetn)
        (loaded && s_addr > psc_pkg::ADDR_MAX) |=> !address_valid;
    endproperty
    a_range_bad: assert property (p_range_bad)
        else $error("address above 223 marked valid");
    property p_cmp_bad;
        @(posedge aclk) disable iff (!aresetn)
        (state == psc_pkg::PSC_UNINIT && err_cmp) |=> ##1 config_error;
    endproperty
    a_cmp_bad: assert property (p_cmp_bad)
        else $error("complement mismatch not flagged");
    property p_hold_uninit;
        @(posedge aclk) disable iff (!aresetn)
        (state == psc_pkg::PSC_UNINIT && secs_left != 11'h0 && !skip_wait)
            |=> uninitialized_link_state;
    endproperty
    a_hold_uninit: assert property (p_hold_uninit)
        else $error("left uninitialized state early");
    property p_fault_holds;
        @(posedge aclk) disable iff (!aresetn)
        config_error |=> config_error && uninitialized_link_state;
    endproperty
    a_fault_holds: assert property (p_fault_holds)
        else $error("fault state not held");
    property p_boot_load;
        @(posedge aclk) disable iff (!aresetn)
        (state == psc_pkg::PSC_SETTLE && settle == 2'h3 &&
            sync2[11:8] == 4'h0) |=>
            secs_left == 11'(psc_pkg::BOOT_MAX_S);
    endproperty
    a_boot_load: assert property (p_boot_load)
        else $error("default boot wait not 1500");
    property p_nodes;
        @(posedge aclk) disable iff (!aresetn)
        (loaded && s_nodes == 2'h2) |=> arb_node_count == psc_pkg::NODES_64;
    endproperty
    a_nodes: assert property (p_nodes)
        else $error("node count wrong");
    property p_bypass;
        @(posedge aclk) disable iff (!aresetn)
        $rose(s_arb) |=> arbitration_bypass;
    endproperty
    a_bypass: assert property (p_bypass)
        else $error("bypass not applied");
    property p_ack;
        @(posedge aclk) disable iff (!aresetn)
        s_ack |=> ack_timeout == ACK_TMO_EXT;
    endproperty
    a_ack: assert property (p_ack)
        else $error("ack extension not applied");
    property p_slot_bad;
        @(posedge aclk) disable iff (!aresetn)
        (state == psc_pkg::PSC_UNINIT && err_slot) |=> ##1 config_error;
    endproperty
    a_slot_bad: assert property (p_slot_bad)
        else $error("illegal slot straps not flagged");
    c_ready: cover property (@(posedge aclk) disable iff (!aresetn)
        $fell(uninitialized_link_state));
    c_fault: cover property (@(posedge aclk) disable iff (!aresetn)
        $rose(config_error));
    c_read: cover property (@(posedge aclk) disable iff (!aresetn)
        s_axi_rvalid && s_axi_rready);
endmodule : psc_strap_config

// ==== psc_strap_model.sv ====
`timescale 1ns/10ps
module psc_strap_model (
    input wire logic [7:0] set_addr,
    input wire logic corrupt_cmp,
    input wire logic [3:0] set_boot,
    input wire logic set_arb_off,
    input wire logic set_hdr_ext,
    input wire logic [2:0] set_delta,
    input wire logic [1:0] set_nodes,
    input wire logic set_ack_ext,
    output logic [7:0] strap_addr,
    output logic [7:0] strap_addr_cmp,
    output logic [3:0] strap_boot,
    output logic strap_arb_off,
    output logic strap_hdr_ext,
    output logic [2:0] strap_delta,
    output logic [1:0] strap_nodes,
    output logic strap_ack_ext
);
    // installed jumper reads as one; values above 223 only when commanded
    assign strap_addr = set_addr;
    // complement copy follows the primary unless told to disagree
    assign strap_addr_cmp = corrupt_cmp ? ~set_addr : set_addr;
    assign strap_boot = set_boot;
    assign strap_arb_off = set_arb_off;
    assign strap_hdr_ext = set_hdr_ext;
    assign strap_delta = set_delta;
    assign strap_nodes = set_nodes;
    assign strap_ack_ext = set_ack_ext;
endmodule : psc_strap_model

// ==== port_adapter_strap_config_tb_top.sv ====
`timescale 1ns/10ps
module port_adapter_strap_config_tb_top;
    localparam logic [7:0] HS_N = 8'h06, HS_E = 8'h0c;
    localparam logic [15:0] AT_N = 16'h0080, AT_E = 16'h0200;
    localparam int BOOT_TAB [16] = '{1500, 1400, 1200, 1300, 1100, 1000,
        900, 800, 700, 600, 500, 400, 300, 200, 100, 0};
    localparam int SLOT_TAB [8] = '{7, 10, 14, 16, 21, 25, 32, 0};
    logic aclk = 0, aresetn = 0;
    logic [7:0] m_addr = 0;
    logic m_bad = 0, m_arb = 0, m_hdr = 0, m_ack = 0;
    logic [3:0] m_boot = 0;
    logic [2:0] m_delta = 0;
    logic [1:0] m_nodes = 0;
    logic [7:0] s_addr, s_cmp, node_address, arb_node_count, header_sync_count;
    logic [3:0] s_boot;
    logic [2:0] s_delta;
    logic [1:0] s_nodes, bresp, rresp;
    logic s_arb, s_hdr, s_ack, address_valid, uninit, config_error, bypass;
    logic [5:0] quiet_slot_count;
    logic [15:0] ack_timeout;
    logic [7:0] awaddr = 0, araddr = 0;
    logic [31:0] wdata = 0, rdata;
    logic awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
    logic awready, wready, bvalid, arready, rvalid;
    int miscompares = 0, comparisons = 0, cycles = 0, seed = 10;
    always #5 aclk = ~aclk;
    psc_strap_model model (.set_addr(m_addr), .corrupt_cmp(m_bad),
        .set_boot(m_boot), .set_arb_off(m_arb), .set_hdr_ext(m_hdr),
        .set_delta(m_delta), .set_nodes(m_nodes), .set_ack_ext(m_ack),
        .strap_addr(s_addr), .strap_addr_cmp(s_cmp), .strap_boot(s_boot),
        .strap_arb_off(s_arb), .strap_hdr_ext(s_hdr), .strap_delta(s_delta),
        .strap_nodes(s_nodes), .strap_ack_ext(s_ack));
    psc_strap_config #(.SEC_CYCLES(10), .HDR_SYNC_NORMAL(HS_N),
        .HDR_SYNC_EXT(HS_E), .ACK_TMO_NORMAL(AT_N), .ACK_TMO_EXT(AT_E),
        .SLOT_HIGH_BIT(2)) dut (.aclk(aclk), .aresetn(aresetn),
        .strap_addr(s_addr), .strap_addr_cmp(s_cmp), .strap_boot(s_boot),
        .strap_arb_off(s_arb), .strap_hdr_ext(s_hdr), .strap_delta(s_delta),
        .strap_nodes(s_nodes), .strap_ack_ext(s_ack),
        .node_address(node_address), .address_valid(address_valid),
        .uninitialized_link_state(uninit), .config_error(config_error),
        .arbitration_bypass(bypass), .header_sync_count(header_sync_count),
        .quiet_slot_count(quiet_slot_count), .arb_node_count(arb_node_count),
        .ack_timeout(ack_timeout), .s_axi_awaddr(awaddr),
        .s_axi_awvalid(awvalid), .s_axi_awready(awready),
        .s_axi_wdata(wdata), .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid),
        .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
        .s_axi_bready(bready), .s_axi_araddr(araddr),
        .s_axi_arvalid(arvalid), .s_axi_arready(arready),
        .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
        .s_axi_rready(rready));
    task automatic wrap_up;
        $display("comparisons %0d miscompares %0d", comparisons, miscompares);
        if (miscompares == 0 && comparisons > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask : wrap_up
    always @(posedge aclk) begin
        cycles <= cycles + 1;
        if (cycles == 60000) begin
            miscompares++;
            wrap_up();
        end
    end
    task automatic chk(input string n, input logic [31:0] e,
            input logic [31:0] g);
        comparisons++;
        if (g !== e) begin
            miscompares++;
            $display("MISMATCH %s expected %h seen %h", n, e, g);
        end
    endtask : chk
    task automatic chk_rng(input string n, input int lo, input int hi,
            input logic signed [31:0] g);
        comparisons++;
        if ($isunknown(g) || g < lo || g > hi) begin
            miscompares++;
            $display("MISMATCH %s expected %0d..%0d seen %0d", n, lo, hi, g);
        end
    endtask : chk_rng
    task automatic axi_wr(input logic [7:0] a, input logic [31:0] d,
            output logic [1:0] r);
        @(posedge aclk);
        awaddr <= a;
        wdata <= d;
        awvalid <= 1;
        wvalid <= 1;
        bready <= 1;
        forever begin
            @(posedge aclk);
            if (awvalid && awready === 1'b1) awvalid <= 0;
            if (wvalid && wready === 1'b1) wvalid <= 0;
            if (bvalid === 1'b1) begin
                r = bresp;
                bready <= 0;
                break;
            end
        end
    endtask : axi_wr
    task automatic axi_rd(input logic [7:0] a, output logic [31:0] d,
            output logic [1:0] r);
        @(posedge aclk);
        araddr <= a;
        arvalid <= 1;
        rready <= 1;
        forever begin
            @(posedge aclk);
            if (arvalid && arready === 1'b1) arvalid <= 0;
            if (rvalid === 1'b1) begin
                d = rdata;
                r = rresp;
                rready <= 0;
                break;
            end
        end
    endtask : axi_rd
    task automatic restart;
        @(posedge aclk);
        aresetn <= 0;
        repeat (2) @(posedge aclk);
        chk("uninit_in_reset", 1, uninit);
        chk("error_in_reset", 0, config_error);
        aresetn <= 1;
    endtask : restart
    function automatic logic [31:0] cfg_word;
        logic [31:0] w;
        w = {5'h0, m_ack, m_hdr, m_arb, 8'(16 << m_nodes), 2'h0,
            6'(SLOT_TAB[m_delta]), m_addr};
        if (m_delta == 3'h7) w[13:8] = 6'h0;
        return w;
    endfunction : cfg_word
    task automatic check_cfg;
        logic [31:0] d, st;
        logic [1:0] r;
        logic bad, err;
        bad = m_addr > 8'hdf || m_bad;
        err = bad || m_delta == 3'h7;
        repeat (8) @(posedge aclk);
        chk("node_address", m_addr, node_address);
        chk("address_valid", !bad, address_valid);
        if (m_delta != 3'h7)
            chk("quiet_slot", SLOT_TAB[m_delta], quiet_slot_count);
        chk("arb_nodes", 16 << m_nodes, arb_node_count);
        chk("bypass", m_arb, bypass);
        chk("hdr_sync", m_hdr ? HS_E : HS_N, header_sync_count);
        chk("ack_tmo", m_ack ? AT_E : AT_N, ack_timeout);
        chk("config_error", err, config_error);
        axi_rd(8'h00, d, r);
        if (m_delta == 3'h7) d[13:8] = 6'h0;
        chk("config_reg", cfg_word(), d);
        axi_rd(8'h04, d, r);
        st = {26'h0, 1'b1, m_delta == 3'h7, m_addr > 8'hdf, m_bad, err, 1'b1};
        chk("status_reg", st, d & 32'h3f);
        axi_rd(8'h08, d, r);
        chk_rng("wait_reg", BOOT_TAB[m_boot] - 1, BOOT_TAB[m_boot], d);
        if (err) chk("uninit_held", 1, uninit);
    endtask : check_cfg
    task automatic measure(input logic [3:0] b);
        int n;
        m_boot <= b;
        m_delta <= 3'($random(seed)) & 3'h3;
        m_addr <= 8'h21;
        m_bad <= 0;
        restart();
        n = 0;
        while (uninit !== 1'b0 && n < 20000) begin
            @(posedge aclk);
            n++;
        end
        chk_rng("boot_wait", BOOT_TAB[b] * 10, BOOT_TAB[b] * 10 + 12, n);
        $display("test boot wait %0d done", BOOT_TAB[b]);
    endtask : measure
    initial begin
        logic [31:0] d;
        logic [1:0] r;
        restart();
        for (int i = 0; i < 16; i++) begin
            m_addr <= (i == 3) ? 8'hdf : (i == 5) ? 8'he0 :
                (i == 12) ? 8'hff : 8'($unsigned($random(seed)) % 224);
            m_bad <= i == 9;
            m_boot <= 4'(i);
            m_delta <= 3'(i);
            m_nodes <= 2'(i);
            {m_arb, m_hdr, m_ack} <= 3'($random(seed));
            restart();
            check_cfg();
            $display("test strap set %0d done", i);
        end
        measure(4'hf);
        measure(4'he);
        measure(4'h0);
        m_boot <= 4'h0;
        restart();
        repeat (8) @(posedge aclk);
        axi_wr(8'h00, 32'hffffffff, r);
        chk("cfg_wr_resp", 2'h0, r);
        axi_rd(8'h00, d, r);
        chk("cfg_ro", cfg_word(), d);
        axi_wr(8'h10, 32'h1, r);
        chk("unmapped_wr", 2'h2, r);
        axi_rd(8'h10, d, r);
        chk("unmapped_rd", 2'h2, r);
        chk("unmapped_data", 0, d);
        chk("uninit_before_skip", 1, uninit);
        axi_wr(8'h0c, 32'h1, r);
        repeat (3) @(posedge aclk);
        chk("uninit_after_skip", 0, uninit);
        axi_rd(8'h0c, d, r);
        chk("ctrl_reg", 1, d & 32'h1);
        $display("test register access done");
        wrap_up();
    end
endmodule : port_adapter_strap_config_tb_top
